// [hdl/lfs_defines.svh]
// constants for the laser fault supervisor
`ifndef LFS_DEFINES_SVH
`define LFS_DEFINES_SVH

// program image loaded after power-up and reset
`define LFS_IMAGE_BYTES      11'd1986
`define LFS_IMAGE_AW         11
// bias and current pin ground-short inputs must persist this many cycles before they trip the running laser
`define LFS_FILT_CYCLES      4'd4
// self-test phase lengths in clock cycles
`define LFS_PHASE_CYCLES     8'd32
`define LFS_STATUS_W         4
// status bit positions
`define LFS_ST_SHORT_GND     0
`define LFS_ST_SHORT_SUPPLY  1
`define LFS_ST_DETECTOR_BAD  2
`define LFS_ST_RUN_FAULT     3

`endif

// [hdl/lfs_pkg.sv]
// types for the laser fault supervisor
package lfs_pkg;

    typedef enum logic [2:0] {
        LFS_LOAD,
        LFS_IDLE,
        LFS_T_GND,
        LFS_T_SUP,
        LFS_T_DET,
        LFS_TRIP
    } lfs_state_t;

    // analog sense comparators at the laser pins
    typedef struct packed {
        logic bias_short_gnd;     // bias resistor pin pulled to ground
        logic current_short_gnd;  // laser current pin pulled to ground
        logic current_short_sup;  // laser current pin pulled to supply rail
        logic detector_tripped;   // fault detector output on the current pin
    } lfs_sense_t;

    // load stream from the serial port burst engine
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } lfs_byte_t;

endpackage : lfs_pkg

// [hdl/lfs_image_ram.sv]
// volatile program memory filled by the burst loader
`timescale 1ns/1ps
`default_nettype none
module lfs_image_ram
    import lfs_pkg::*;
#(
    parameter int DEPTH = 1986,
    parameter int AW    = 11
) (
    // clock
    input  wire logic          clk,
    // write side
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    // read side
    input  wire logic [AW-1:0] rd_addr,
    output logic      [7:0]    rd_data
);

    logic [7:0] mem [DEPTH];

    // no reset: contents are volatile and reloaded after every reset
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule : lfs_image_ram
`default_nettype wire

// [hdl/lfs_supervisor.sv]
// laser fault supervisor: enable, fault trip, write-triggered self-test
//
// Operation
// - a short to ground on the bias or current pin turns the drive off and forces the enable high.
// - the active-low switch enable is held low while no fault is present.
// - once the image is loaded, a write of the first power configuration register starts a self-test; writes during the load set the level but start no test.
// - the self-test checks the current pin for shorts to ground and to the supply rail.
// - the self-test forces the detector and checks that it responds.
// - after power-up and reset the 1986-byte image is burst-loaded and run from memory.
// - continuous mode lights the laser whenever powered up once the image is loaded; shutter mode only in the exposure part and during a self-test.
`timescale 1ns/1ps
`default_nettype none
`include "lfs_defines.svh"
module lfs_supervisor
    import lfs_pkg::*;
#(
    parameter int IMAGE_BYTES = 1986
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // power control
    input  wire logic         power_down_n,
    input  wire logic         drive_continuous,
    input  wire logic         exposure_window,
    // configuration write strobes
    input  wire logic         laser_power_cfg_first_wr,
    input  wire logic         laser_power_cfg_second_wr,
    input  wire logic [7:0]   cfg_wdata,
    // program image burst stream
    input  wire lfs_byte_t    load_in,
    input  wire logic [10:0]  prog_rd_addr,
    output logic      [7:0]   prog_rd_data,
    output logic              image_ready,
    // analog front end
    input  wire lfs_sense_t   sense,
    output logic              force_detector,
    output logic              drive_on,
    output logic      [7:0]   drive_level_first,
    output logic      [7:0]   drive_level_second,
    // laser switch and status
    output logic              laser_switch_enable_n,
    output logic              fault_latched,
    output logic              self_test_busy,
    output logic      [`LFS_STATUS_W-1:0] test_status
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    lfs_state_t                 state_q, state_d;
    logic [10:0]                addr_q, addr_d;
    logic [7:0]                 tmr_q, tmr_d;
    logic [3:0]                 filt_q, filt_d;
    logic                       seen_q, seen_d;
    logic                       pend_q, pend_d;
    logic                       fault_q, fault_d;
    logic [`LFS_STATUS_W-1:0]   stat_q, stat_d;
    logic [7:0]                 lvl0_q, lvl0_d, lvl1_q, lvl1_d;
    logic                       run_short;
    logic                       phase_end;
    logic                       load_we;

    assign run_short = sense.bias_short_gnd | sense.current_short_gnd;
    assign phase_end = (tmr_q == `LFS_PHASE_CYCLES - 8'h01);
    assign load_we   = (state_q == LFS_LOAD) && load_in.valid;

    lfs_image_ram #(
        .DEPTH (IMAGE_BYTES),
        .AW    (`LFS_IMAGE_AW)
    ) u_ram (
        .clk     (clk),
        .wr_en   (load_we),
        .wr_addr (addr_q),
        .wr_data (load_in.data),
        .rd_addr (prog_rd_addr),
        .rd_data (prog_rd_data)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        addr_d  = addr_q;
        tmr_d   = tmr_q;
        filt_d  = filt_q;
        seen_d  = seen_q;
        pend_d  = pend_q;
        fault_d = fault_q;
        stat_d  = stat_q;
        lvl0_d  = lvl0_q;
        lvl1_d  = lvl1_q;

        if (laser_power_cfg_first_wr) begin
            lvl0_d = cfg_wdata;
        end
        if (laser_power_cfg_second_wr) begin
            lvl1_d = cfg_wdata;
        end

        // a glitch on the comparators must not trip the laser for good
        if (run_short) begin
            if (filt_q != `LFS_FILT_CYCLES) begin
                filt_d = filt_q + 4'h1;
            end
        end else begin
            filt_d = 4'h0;
        end
        if (filt_q == `LFS_FILT_CYCLES) begin
            fault_d = 1'b1;
            stat_d[`LFS_ST_RUN_FAULT] = 1'b1;
        end

        // a write arriving mid-test restarts after the current one ends
        if (laser_power_cfg_first_wr && state_q != LFS_LOAD) begin
            pend_d = 1'b1;
        end

        unique case (state_q)
            LFS_LOAD: begin
                if (load_in.valid) begin
                    if (addr_q == 11'(IMAGE_BYTES - 1)) begin
                        state_d = LFS_IDLE;
                    end else begin
                        addr_d = addr_q + 11'h001;
                    end
                end
            end
            LFS_IDLE: begin
                if (fault_q) begin
                    state_d = LFS_TRIP;
                end else if (pend_q) begin
                    // a write in the start cycle must not be lost
                    pend_d  = laser_power_cfg_first_wr;
                    tmr_d   = 8'h00;
                    seen_d  = 1'b0;
                    stat_d[`LFS_ST_SHORT_GND]    = 1'b0;
                    stat_d[`LFS_ST_SHORT_SUPPLY] = 1'b0;
                    stat_d[`LFS_ST_DETECTOR_BAD] = 1'b0;
                    state_d = LFS_T_GND;
                end
            end
            LFS_T_GND: begin
                tmr_d = tmr_q + 8'h01;
                if (sense.current_short_gnd) begin
                    stat_d[`LFS_ST_SHORT_GND] = 1'b1;
                    fault_d = 1'b1;
                end
                if (phase_end) begin
                    tmr_d   = 8'h00;
                    state_d = LFS_T_SUP;
                end
            end
            LFS_T_SUP: begin
                tmr_d = tmr_q + 8'h01;
                if (sense.current_short_sup) begin
                    stat_d[`LFS_ST_SHORT_SUPPLY] = 1'b1;
                    fault_d = 1'b1;
                end
                if (phase_end) begin
                    tmr_d   = 8'h00;
                    state_d = LFS_T_DET;
                end
            end
            LFS_T_DET: begin
                tmr_d = tmr_q + 8'h01;
                if (sense.detector_tripped) begin
                    seen_d = 1'b1;
                end
                if (phase_end) begin
                    tmr_d = 8'h00;
                    if (!(seen_q || sense.detector_tripped)) begin
                        stat_d[`LFS_ST_DETECTOR_BAD] = 1'b1;
                        fault_d = 1'b1;
                    end
                    state_d = LFS_IDLE;
                end
            end
            LFS_TRIP: begin
                // only reset clears a trip; the laser stays dark
                state_d = LFS_TRIP;
            end
            default: begin
                // spare codes: an upset lands in the dark state
                state_d = LFS_TRIP;
            end
        endcase

        if (fault_d && state_d == LFS_IDLE) begin
            state_d = LFS_TRIP;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= LFS_LOAD;
            addr_q  <= 11'h000;
            tmr_q   <= 8'h00;
            filt_q  <= 4'h0;
            seen_q  <= 1'b0;
            pend_q  <= 1'b0;
            fault_q <= 1'b0;
            stat_q  <= '0;
            lvl0_q  <= 8'h00;
            lvl1_q  <= 8'h00;
        end else begin
            state_q <= state_d;
            addr_q  <= addr_d;
            tmr_q   <= tmr_d;
            filt_q  <= filt_d;
            seen_q  <= seen_d;
            pend_q  <= pend_d;
            fault_q <= fault_d;
            stat_q  <= stat_d;
            lvl0_q  <= lvl0_d;
            lvl1_q  <= lvl1_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic drive_on_d, drive_on_q;
    logic enable_n_q;

    // the self-test runs with the current source on so faults show
    always_comb begin
        drive_on_d = 1'b0;
        if (!fault_d && state_d != LFS_LOAD && state_d != LFS_TRIP
            && power_down_n) begin
            drive_on_d = drive_continuous | exposure_window
                       | (state_d != LFS_IDLE);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            drive_on_q <= 1'b0;
            enable_n_q <= 1'b1;
        end else begin
            drive_on_q <= drive_on_d;
            enable_n_q <= fault_d;
        end
    end

    assign drive_on              = drive_on_q;
    assign laser_switch_enable_n = enable_n_q;
    assign force_detector        = (state_q == LFS_T_DET);
    assign drive_level_first     = lvl0_q;
    assign drive_level_second    = lvl1_q;
    assign image_ready           = (state_q != LFS_LOAD);
    assign fault_latched         = fault_q;
    assign self_test_busy        = (state_q == LFS_T_GND)
                                 || (state_q == LFS_T_SUP)
                                 || (state_q == LFS_T_DET);
    assign test_status           = stat_q;

endmodule : lfs_supervisor
`default_nettype wire

// [tb/lfs_properties.sv]
// assertions for the laser fault supervisor
`timescale 1ns/1ps
`default_nettype none
`include "lfs_defines.svh"
module lfs_properties
    import lfs_pkg::*;
#(
    parameter int IMAGE_BYTES = 1986
) (
    // clock and reset
    input wire logic                     clk,
    input wire logic                     reset,
    // watched inputs
    input wire logic                     power_down_n,
    input wire logic                     laser_power_cfg_first_wr,
    input wire lfs_byte_t                load_in,
    input wire lfs_sense_t               sense,
    // watched outputs
    input wire logic                     image_ready,
    input wire logic                     force_detector,
    input wire logic                     drive_on,
    input wire logic                     laser_switch_enable_n,
    input wire logic                     fault_latched,
    input wire logic                     self_test_busy,
    input wire logic [`LFS_STATUS_W-1:0] test_status
);
    logic [11:0] load_cnt_q, load_cnt_d;
    logic [7:0]  busy_cnt_q, busy_cnt_d;

    // busy counter wraps per test so queued tests stay in step
    always_comb begin
        load_cnt_d = load_cnt_q + 12'(load_in.valid && !image_ready);
        busy_cnt_d = (self_test_busy && busy_cnt_q != 8'h5F) ?
                     busy_cnt_q + 8'h01 : 8'h00;
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            load_cnt_q <= 12'h000;
            busy_cnt_q <= 8'h00;
        end else begin
            load_cnt_q <= load_cnt_d;
            busy_cnt_q <= busy_cnt_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    bias_trip_a: assert property ((image_ready && sense.bias_short_gnd) [*5]
        |-> ##[1:2] (laser_switch_enable_n && !drive_on))
        else $error("bias short did not trip");
    pin_trip_a: assert property ((image_ready && sense.current_short_gnd) [*5]
        |-> ##[1:2] (laser_switch_enable_n && !drive_on))
        else $error("current pin short did not trip");
    fault_hold_a: assert property (fault_latched |=>
        fault_latched && laser_switch_enable_n && !drive_on)
        else $error("fault not held");
    enable_low_a: assert property ((!fault_latched && power_down_n) [*2]
        |-> !laser_switch_enable_n)
        else $error("enable released without fault");
    test_start_a: assert property (laser_power_cfg_first_wr && image_ready
        && !self_test_busy && !fault_latched |-> ##2 self_test_busy)
        else $error("self-test did not start");
    test_len_a: assert property ($fell(self_test_busy) && !fault_latched
        |-> $past(busy_cnt_q) == 8'h5F)
        else $error("self-test length wrong");
    force_phase_a: assert property ($rose(force_detector)
        |-> self_test_busy && busy_cnt_q == 8'h40)
        else $error("detector forced outside its phase");
    load_done_a: assert property ($rose(image_ready)
        |-> load_cnt_q == 12'(IMAGE_BYTES))
        else $error("image ready at wrong byte count");
    pd_dark_a: assert property (!power_down_n [*2] |-> !drive_on)
        else $error("drive on in power down");
    status_fault_a: assert property ((test_status != 4'h0)
        |-> fault_latched)
        else $error("status bit set without latched fault");

    cover property ($rose(image_ready));
    cover property ($fell(self_test_busy) && !fault_latched);
    cover property ($rose(fault_latched));
endmodule : lfs_properties

bind lfs_supervisor lfs_properties #(.IMAGE_BYTES(IMAGE_BYTES))
    lfs_properties_i (.clk, .reset, .power_down_n,
    .laser_power_cfg_first_wr, .load_in, .sense, .image_ready,
    .force_detector, .drive_on, .laser_switch_enable_n, .fault_latched,
    .self_test_busy, .test_status);
`default_nettype wire

// [tb/lfs_far_side.sv]
// controller image stream and laser pin comparators
`timescale 1ns/1ps
`default_nettype none
module lfs_far_side
    import lfs_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // faults requested by the bench; detector_tripped means broken
    input  wire lfs_sense_t inject,
    // supervisor side
    input  wire logic       force_detector,
    output lfs_byte_t       load_out,
    output lfs_sense_t      sense
);
    logic [10:0] addr_q;

    always @(posedge clk or posedge reset)
        if (reset) addr_q <= 11'h000;
        else if (load_out.valid) addr_q <= addr_q + 11'h001;
    assign load_out.valid = !reset && addr_q != 11'h7C2;
    assign load_out.data  = addr_q[7:0] ^ 8'h5A;
    assign sense.bias_short_gnd    = inject.bias_short_gnd;
    assign sense.current_short_gnd = inject.current_short_gnd;
    assign sense.current_short_sup = inject.current_short_sup;
    // a grounded pin also looks like a detector hit
    assign sense.detector_tripped  = (force_detector
        && !inject.detector_tripped) || inject.current_short_gnd;
endmodule : lfs_far_side
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the laser fault supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lfs_pkg::*;
    logic clk = 1'b0, reset = 1'b1, power_down_n = 1'b1;
    logic drive_continuous = 1'b1, exposure_window = 1'b0;
    logic laser_power_cfg_first_wr = 1'b0, laser_power_cfg_second_wr = 1'b0;
    logic [7:0] cfg_wdata = 8'h00, prog_rd_data;
    logic [7:0] drive_level_first, drive_level_second;
    logic [10:0] prog_rd_addr = 11'h000;
    logic [3:0] test_status;
    logic image_ready, force_detector, drive_on, laser_switch_enable_n;
    logic fault_latched, self_test_busy;
    lfs_byte_t  load_in;
    lfs_sense_t sense, inject = '0;
    int error_cnt = 0, tests_run = 0, cycles = 0;
    logic [3:0] mrow [6] = '{4'hD, 4'hF, 4'hB, 4'h8, 4'h6, 4'h2};
    logic [3:0] frow [4] = '{4'h2, 4'h1, 4'h8, 4'h4};

    lfs_supervisor lfs_supervisor_i (.clk, .reset, .power_down_n,
        .drive_continuous, .exposure_window, .laser_power_cfg_first_wr,
        .laser_power_cfg_second_wr, .cfg_wdata, .load_in, .prog_rd_addr,
        .prog_rd_data, .image_ready, .sense, .force_detector, .drive_on,
        .drive_level_first, .drive_level_second, .laser_switch_enable_n,
        .fault_latched, .self_test_busy, .test_status);
    lfs_far_side lfs_far_side_i (.clk, .reset, .inject, .force_detector,
        .load_out(load_in), .sense);

    always #12.5 clk = ~clk;

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    task automatic restart;
        inject = '0;
        reset = 1'b1;
        tick(10);
        check("enable_n_rst", laser_switch_enable_n, 1);
        reset = 1'b0;
        tick(1985);
        check("early_ready", image_ready, 0);
        check("dark_load", drive_on, 0);
        tick(1);
        check("image_ready", image_ready, 1);
    endtask : restart

    task automatic write_first(logic [7:0] v);
        cfg_wdata = v;
        laser_power_cfg_first_wr = 1'b1;
        tick(1);
        laser_power_cfg_first_wr = 1'b0;
    endtask : write_first

    task automatic wait_idle;
        for (int i = 0; i < 200 && self_test_busy; i++) tick(1);
    endtask : wait_idle

    initial begin
        restart();
        prog_rd_addr = 11'h000;
        tick(1);
        check("image_lo", prog_rd_data, 8'h5A);
        prog_rd_addr = 11'h7C1;
        tick(1);
        check("image_hi", prog_rd_data, 8'h9B);
        foreach (mrow[k]) begin
            {power_down_n, drive_continuous, exposure_window} = mrow[k][3:1];
            tick(3);
            check("drive_mode", drive_on, mrow[k][0]);
            if (power_down_n)
                check("enable_n", laser_switch_enable_n, 0);
        end
        {power_down_n, drive_continuous} = 2'b11;
        write_first(8'h3C);
        tick(2);
        check("busy", self_test_busy, 1);
        check("no_force", force_detector, 8'h00);
        tick(20);
        write_first(8'h3D);
        tick(50);
        check("force_det", force_detector, 8'h01);
        wait_idle();
        tick(3);
        check("queued", self_test_busy, 1);
        wait_idle();
        check("status", test_status, 8'h00);
        check("level1", drive_level_first, 8'h3D);
        cfg_wdata = 8'hC3;
        laser_power_cfg_second_wr = 1'b1;
        tick(1);
        laser_power_cfg_second_wr = 1'b0;
        tick(1);
        check("level2", drive_level_second, 8'hC3);
        foreach (frow[k]) begin
            restart();
            if (frow[k] > 4'h3) begin
                inject = frow[k];
                tick(3);
                inject = '0;
                tick(3);
                check("glitch", fault_latched, 0);
                inject = frow[k];
                tick(8);
            end else begin
                inject = frow[k];
                write_first(8'h10);
                tick(2);
                wait_idle();
                tick(2);
            end
            check("fstatus", test_status, frow[k] > 4'h3 ? 4'h8 :
                {1'b0, frow[k][0], frow[k][1], 1'b0});
            check("fenable_n", laser_switch_enable_n, 1);
            check("fdrive", drive_on, 0);
            check("flatch", fault_latched, 8'h01);
        end
        // current pin grounded once the self-test is under way
        restart();
        write_first(8'h10);
        tick(2);
        inject = 4'h4;
        wait_idle();
        tick(2);
        check("gnd_status", test_status, 8'h09);
        check("gnd_enable_n", laser_switch_enable_n, 8'h01);
        check("gnd_drive", drive_on, 8'h00);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
